// *** logic/bmc_ctrl.sv ***
// Bus controller: mode commands, status collection and medium fault handling.
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl #(
   parameter int SUBFRAME_CYCLES = bmc_pkg::SUBFRAME_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // User command port.
   input wire logic cmd_valid_i,
   input wire logic [4:0] cmd_addr_i,
   input wire logic cmd_tx_i,
   input wire logic [4:0] cmd_sa_i,
   input wire logic [4:0] cmd_wc_i,
   output logic cmd_ready_o,
   output logic cmd_refused_o,
   // User data words and results.
   input wire logic dat_valid_i,
   input wire logic [15:0] dat_i,
   output logic dat_ack_o,
   output logic [15:0] rx_word_o,
   output logic rx_word_valid_o,
   output logic done_o,
   output logic [15:0] stat_o,
   output logic [6:0] flt_o,
   output logic rt_fail_o,
   // Medium control.
   input wire logic auto_en_i,
   input wire logic sel_a_i,
   input wire logic sel_b_i,
   output logic bus_b_o,
   output logic bus_sel_o,
   // Bus encoder, decoder and loop-back monitor.
   output logic [15:0] tx_word_o,
   output logic tx_valid_o,
   output logic tx_cmd_o,
   input wire logic tx_ready_i,
   input wire logic rx_valid_i,
   input wire logic rx_stat_i,
   input wire logic [15:0] rx_dat_i,
   input wire logic rx_err_i,
   input wire logic lb_fail_i
);
   bmc_pkg::bmc_state_s r;
   bmc_pkg::bmc_state_s n;

   // Only assigned mode codes pass; transmit-type codes cannot be broadcast.
   function automatic logic mode_ok(input logic [4:0] c, input logic bc, input logic t);
      case (c)
         bmc_pkg::MC_SYNC: mode_ok = bc && t;
         bmc_pkg::MC_SYNC_DAT: mode_ok = bc && !t;
         bmc_pkg::MC_TX_STATUS, bmc_pkg::MC_TX_VECTOR,
         bmc_pkg::MC_TX_LAST, bmc_pkg::MC_TX_BIT: mode_ok = t && !bc;
         bmc_pkg::MC_SELF_TEST, bmc_pkg::MC_TX_SHDN, bmc_pkg::MC_OVR_SHDN,
         bmc_pkg::MC_INH_TF, bmc_pkg::MC_OVR_INH_TF, bmc_pkg::MC_RESET_RT: mode_ok = t;
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // Next-state logic for the whole controller.
   always_comb
   begin
      logic [6:0] ferr;
      logic fin;
      logic ismode;
      logic legal;
      ferr = '0;
      fin = 1'b0;
      ismode = (cmd_sa_i == bmc_pkg::SA_MODE0) || (cmd_sa_i == bmc_pkg::SA_MODE1);
      legal = ismode ? mode_ok(cmd_wc_i, cmd_addr_i == bmc_pkg::BCAST_ADDR, cmd_tx_i)
                     : !(cmd_tx_i && (cmd_addr_i == bmc_pkg::BCAST_ADDR));
      n = r;
      n.refused = 1'b0;
      n.done = 1'b0;
      n.dat_ack = 1'b0;
      n.rx_wvalid = 1'b0;
      n.rt_fail = 1'b0;
      n.lb_pend = r.lb_pend | lb_fail_i;
      unique case (r.st)
         bmc_pkg::ST_IDLE:
         begin
            if (r.sync_pend)
            begin
               // Frame sync has priority over user traffic.
               n.sync_pend = 1'b0;
               n.addr = bmc_pkg::BCAST_ADDR;
               n.bc = 1'b1;
               n.tx = 1'b0;
               n.own = (r.sub_cnt != 6'h00);
               n.cnt = (r.sub_cnt != 6'h00) ? 6'h01 : 6'h00;
               n.tx_word = {bmc_pkg::BCAST_ADDR, r.sub_cnt == 6'h00, bmc_pkg::SA_MODE0,
                            (r.sub_cnt == 6'h00) ? bmc_pkg::MC_SYNC : bmc_pkg::MC_SYNC_DAT};
               n.tx_valid = 1'b1;
               n.tx_cmd = 1'b1;
               n.flt = '0;
               n.st = bmc_pkg::ST_SEND;
            end
            else if (cmd_valid_i && r.cmd_ready)
            begin
               if (!legal)
               begin
                  n.refused = 1'b1;
               end
               else
               begin
                  n.addr = cmd_addr_i;
                  n.bc = (cmd_addr_i == bmc_pkg::BCAST_ADDR);
                  n.tx = cmd_tx_i;
                  n.own = 1'b0;
                  if (ismode)
                     n.cnt = {5'h00, cmd_wc_i[4]};
                  else
                     n.cnt = (cmd_wc_i == 5'h00) ? bmc_pkg::WC_FULL : {1'b0, cmd_wc_i};
                  n.tx_word = {cmd_addr_i, cmd_tx_i, cmd_sa_i, cmd_wc_i};
                  n.tx_valid = 1'b1;
                  n.tx_cmd = 1'b1;
                  n.flt = '0;
                  n.st = bmc_pkg::ST_SEND;
               end
            end
         end
         bmc_pkg::ST_SEND:
         begin
            if (r.tx_valid)
            begin
               if (tx_ready_i)
               begin
                  n.tx_valid = 1'b0;
                  n.tx_cmd = 1'b0;
                  if (r.tx || (r.cnt == 6'h00))
                  begin
                     if (r.bc)
                        fin = 1'b1;
                     else
                     begin
                        n.tmo = '0;
                        n.st = bmc_pkg::ST_WSTAT;
                     end
                  end
               end
            end
            else if (r.own)
            begin
               n.tx_word = {10'h000, r.sub_cnt};
               n.tx_valid = 1'b1;
               n.cnt = 6'h00;
            end
            else if (dat_valid_i)
            begin
               n.tx_word = dat_i;
               n.tx_valid = 1'b1;
               n.dat_ack = 1'b1;
               n.cnt = r.cnt - 6'h01;
            end
         end
         bmc_pkg::ST_WSTAT:
         begin
            if (rx_valid_i && rx_stat_i)
            begin
               n.stat = rx_dat_i;
               ferr[bmc_pkg::F_ME] = rx_dat_i[bmc_pkg::SW_ME];
               ferr[bmc_pkg::F_BUSY] = rx_dat_i[bmc_pkg::SW_BUSY];
               ferr[bmc_pkg::F_SUBSYS] = rx_dat_i[bmc_pkg::SW_SUBSYS];
               ferr[bmc_pkg::F_TF] = rx_dat_i[bmc_pkg::SW_TF];
               if (rx_err_i || (rx_dat_i[bmc_pkg::SW_ADDR +: 5] != r.addr))
               begin
                  ferr[bmc_pkg::F_TXERR] = 1'b1;
                  fin = 1'b1;
               end
               else if (r.tx && (r.cnt != 6'h00))
               begin
                  n.tmo = '0;
                  n.st = bmc_pkg::ST_RXDAT;
               end
               else
                  fin = 1'b1;
            end
            else if (r.tmo == bmc_pkg::RESP_CYC)
            begin
               ferr[bmc_pkg::F_NORESP] = 1'b1;
               fin = 1'b1;
            end
            else
               n.tmo = r.tmo + 9'h001;
         end
         bmc_pkg::ST_RXDAT:
         begin
            if (rx_valid_i && !rx_err_i && !rx_stat_i)
            begin
               n.rx_word = rx_dat_i;
               n.rx_wvalid = !r.iso;
               n.cnt = r.cnt - 6'h01;
               n.tmo = '0;
               fin = (r.cnt == 6'h01);
            end
            else if (rx_valid_i || (r.tmo == bmc_pkg::RESP_CYC))
            begin
               // A gap or a bad word inside a reply is a transmission error.
               ferr[bmc_pkg::F_TXERR] = 1'b1;
               fin = 1'b1;
            end
            else
               n.tmo = r.tmo + 9'h001;
         end
      endcase
      // Probe results must not overwrite the faults of the original message.
      if (!r.iso)
         n.flt = n.flt | ferr;
      if (fin)
      begin
         n.st = bmc_pkg::ST_IDLE;
         if (r.iso)
         begin
            // Medium B answered: medium A is the culprit, otherwise the terminal.
            n.iso = 1'b0;
            if (ferr[bmc_pkg::F_TXERR] || ferr[bmc_pkg::F_NORESP])
               n.rt_fail = 1'b1;
            else
               n.bus_b = 1'b1;
            n.done = 1'b1;
         end
         else
         begin
            n.flt[bmc_pkg::F_LOOP] = r.lb_pend | lb_fail_i;
            n.lb_pend = 1'b0;
            if ((ferr[bmc_pkg::F_TXERR] || ferr[bmc_pkg::F_NORESP] || n.flt[bmc_pkg::F_LOOP])
                && !r.bus_b && auto_en_i && !r.bc)
            begin
               // Probe the same terminal on medium B before deciding.
               n.iso = 1'b1;
               n.tx_word = {r.addr, 1'b1, bmc_pkg::SA_MODE0, bmc_pkg::MC_TX_STATUS};
               n.tx_valid = 1'b1;
               n.tx_cmd = 1'b1;
               n.tx = 1'b1;
               n.cnt = 6'h00;
               n.own = 1'b0;
               n.st = bmc_pkg::ST_SEND;
            end
            else
               n.done = 1'b1;
         end
      end
      // Manual medium selection only between messages.
      if ((r.st == bmc_pkg::ST_IDLE) && !r.iso)
      begin
         if (sel_b_i)
            n.bus_b = 1'b1;
         else if (sel_a_i)
            n.bus_b = 1'b0;
      end
      // Subframe timer; a sync is owed at the start of every subframe.
      if (r.sub_tmr == bmc_pkg::TMR_W'(SUBFRAME_CYCLES - 1))
      begin
         n.sub_tmr = '0;
         n.sub_cnt = r.sub_cnt + 6'h01;
      end
      else
         n.sub_tmr = r.sub_tmr + bmc_pkg::TMR_W'(1);
      if (r.sub_tmr == '0)
         n.sync_pend = 1'b1;
      n.sel = n.iso | n.bus_b;
      n.cmd_ready = (n.st == bmc_pkg::ST_IDLE) && !n.sync_pend && !n.iso;
   end

   // State register; reset leaves medium A selected.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= n;
   end

   // Outputs straight from the state register.
   assign cmd_ready_o = r.cmd_ready;
   assign cmd_refused_o = r.refused;
   assign dat_ack_o = r.dat_ack;
   assign rx_word_o = r.rx_word;
   assign rx_word_valid_o = r.rx_wvalid;
   assign done_o = r.done;
   assign stat_o = r.stat;
   assign flt_o = r.flt;
   assign rt_fail_o = r.rt_fail;
   assign bus_b_o = r.bus_b;
   assign bus_sel_o = r.sel;
   assign tx_word_o = r.tx_word;
   assign tx_valid_o = r.tx_valid;
   assign tx_cmd_o = r.tx_cmd;

   // Checks on the controller's own behaviour.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   bad_mode_a:
   assert property (cmd_valid_i && cmd_ready_o && (cmd_sa_i == 5'h00) && (cmd_wc_i inside {5'h00, 5'h14})
      |=> cmd_refused_o && !tx_valid_o) else $error("Unsupported mode code was issued.");
   ovr_sel_a:
   assert property (cmd_valid_i && cmd_ready_o && (cmd_sa_i == 5'h1f) && (cmd_wc_i == 5'h15)
      |=> cmd_refused_o) else $error("Override selected shutdown was issued.");
   reserved_code_a:
   assert property (cmd_valid_i && cmd_ready_o && (cmd_sa_i == 5'h00) && (cmd_wc_i inside {[5'h09:5'h0f], [5'h16:5'h1f]})
      |=> cmd_refused_o) else $error("Reserved mode code was issued.");
   supp_mode_a:
   assert property (cmd_valid_i && cmd_ready_o && (cmd_sa_i == 5'h00) && cmd_tx_i && (cmd_addr_i != 5'h1f)
      && (cmd_wc_i inside {5'h02, 5'h03, 5'h06, 5'h13}) |=> tx_valid_o && tx_cmd_o && !cmd_refused_o)
      else $error("Supported mode code was refused.");
   wc_full_a:
   assert property (cmd_valid_i && cmd_ready_o && (cmd_sa_i == 5'h05) && !cmd_tx_i && (cmd_wc_i == 5'h00)
      |=> r.cnt == 6'h20) else $error("Word count zero did not mean 32.");
   sync_bcast_a:
   assert property (tx_valid_o && tx_cmd_o && (tx_word_o[9:5] == 5'h00) && (tx_word_o[4:0] inside {5'h01, 5'h11})
      |-> tx_word_o[15:11] == 5'h1f) else $error("Sync mode code not broadcast.");
   frame_sync_a:
   assert property (tx_valid_o && tx_cmd_o && (tx_word_o == 16'hfc01) |-> r.sub_cnt == 6'h00)
      else $error("Sync without data outside first subframe.");
   no_resp_a:
   assert property ((r.st == bmc_pkg::ST_WSTAT) && (r.tmo == 9'h154) && !(rx_valid_i && rx_stat_i) && !r.iso
      |=> flt_o[5] && (r.iso || done_o)) else $error("Missing reply not flagged.");
   me_collect_a:
   assert property ((r.st == bmc_pkg::ST_WSTAT) && rx_valid_i && rx_stat_i && rx_dat_i[5] && !r.iso
      |=> flt_o[0]) else $error("Message error bit not collected.");
   probe_only_a:
   assert property (tx_valid_o && bus_sel_o && !bus_b_o |-> r.iso && tx_cmd_o && (tx_word_o[10:0] == 11'h402))
      else $error("Traffic on B outside isolation.");
   b_stays_a:
   assert property ($past(bus_b_o) && !$past(sel_a_i) |-> bus_b_o) else $error("Medium fell back to A.");
   switch_cause_a:
   assert property ($rose(bus_b_o) && !$past(sel_b_i) |-> $past(r.iso) && done_o) else $error("Switch without isolation.");
   rt_report_a:
   assert property (rt_fail_o |-> done_o && !bus_b_o) else $error("Terminal fault reported wrongly.");
   switch_cov: cover property (done_o && $rose(bus_b_o));
   rtfail_cov: cover property (rt_fail_o);
   syncdat_cov: cover property (tx_valid_o && tx_cmd_o && (tx_word_o[4:0] == 5'h11) ##[1:20] tx_valid_o && !tx_cmd_o);
endmodule
`default_nettype wire

// *** logic/bmc_pkg.sv ***
// Constants and types shared by the bus mode code and status controller.
`default_nettype none
package bmc_pkg;
   // Timing: clock period, response wait and subframe length.
   localparam int CLK_NS = 100;
   localparam int RESP_WAIT_NS = 34000;
   localparam logic [8:0] RESP_CYC = 9'(RESP_WAIT_NS / CLK_NS);
   localparam int SUBFRAME_NS = 15625000;
   localparam int SUBFRAME_CYC = SUBFRAME_NS / CLK_NS;
   localparam int TMR_W = 18;
   // Addresses and mode subaddresses.
   localparam logic [4:0] BCAST_ADDR = 5'h1f;
   localparam logic [4:0] SA_MODE0 = 5'h00;
   localparam logic [4:0] SA_MODE1 = 5'h1f;
   // Mode codes.
   localparam logic [4:0] MC_SYNC = 5'h01;
   localparam logic [4:0] MC_TX_STATUS = 5'h02;
   localparam logic [4:0] MC_SELF_TEST = 5'h03;
   localparam logic [4:0] MC_TX_SHDN = 5'h04;
   localparam logic [4:0] MC_OVR_SHDN = 5'h05;
   localparam logic [4:0] MC_INH_TF = 5'h06;
   localparam logic [4:0] MC_OVR_INH_TF = 5'h07;
   localparam logic [4:0] MC_RESET_RT = 5'h08;
   localparam logic [4:0] MC_TX_VECTOR = 5'h10;
   localparam logic [4:0] MC_SYNC_DAT = 5'h11;
   localparam logic [4:0] MC_TX_LAST = 5'h12;
   localparam logic [4:0] MC_TX_BIT = 5'h13;
   // Command word field positions.
   localparam int CW_ADDR = 11;
   localparam int CW_TR = 10;
   localparam int CW_SA = 5;
   localparam int CW_WC = 0;
   localparam logic [5:0] WC_FULL = 6'h20;
   // Status word field positions.
   localparam int SW_ADDR = 0;
   localparam int SW_ME = 5;
   localparam int SW_BUSY = 12;
   localparam int SW_SUBSYS = 13;
   localparam int SW_TF = 15;
   // Fault vector positions.
   localparam int F_ME = 0;
   localparam int F_BUSY = 1;
   localparam int F_SUBSYS = 2;
   localparam int F_TF = 3;
   localparam int F_TXERR = 4;
   localparam int F_NORESP = 5;
   localparam int F_LOOP = 6;
   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WSTAT, ST_RXDAT} bmc_st_e;
   typedef struct packed {
      bmc_st_e st;
      logic iso;
      logic bus_b;
      logic sel;
      logic tx;
      logic bc;
      logic own;
      logic [5:0] cnt;
      logic [8:0] tmo;
      logic [4:0] addr;
      logic [15:0] tx_word;
      logic tx_valid;
      logic tx_cmd;
      logic [15:0] rx_word;
      logic rx_wvalid;
      logic [15:0] stat;
      logic cmd_ready;
      logic refused;
      logic done;
      logic dat_ack;
      logic [6:0] flt;
      logic lb_pend;
      logic rt_fail;
      logic [TMR_W-1:0] sub_tmr;
      logic [5:0] sub_cnt;
      logic sync_pend;
   } bmc_state_s;
endpackage
`default_nettype wire

// *** sim/bmc_rt_model.sv ***
// Remote terminal model with its bus encoder and decoder, facing the controller.
`timescale 1ns/1ps
`default_nettype none
module bmc_rt_model #(
   parameter logic [4:0] MY_ADDR = 5'h05
) (
   // Clock.
   input wire logic clk_i,
   // Encoder and decoder side.
   input wire logic [15:0] tx_word_i,
   input wire logic tx_valid_i,
   input wire logic tx_cmd_i,
   input wire logic bus_sel_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic rx_stat_o,
   output logic [15:0] rx_dat_o,
   output logic rx_err_o,
   // Fault injection from the bench.
   input wire logic dead_a_i,
   input wire logic dead_b_i,
   input wire logic err_i,
   input wire logic [2:0] flags_i
);
   // Mode codes this terminal accepts; any other is an illegal command to it.
   localparam logic [31:0] LEGAL = 32'h000f_01fe;
   logic [15:0] w;
   logic [15:0] cw;
   logic bc_r;
   logic me_r;
   logic md;
   logic live;
   int nrx;
   int ntx;
   int rcvd;
   // Takes one word from the encoder; ready is raised only after valid is seen.
   task automatic take();
      @(posedge clk_i);
      while (tx_valid_i !== 1'b1)
         @(posedge clk_i);
      tx_ready_o <= 1'b1;
      @(posedge clk_i);
      w = tx_word_i;
      tx_ready_o <= 1'b0;
   endtask
   // Sends one decoded word; the data lines then show the inverse, not a stale copy.
   task automatic send(input logic [15:0] d, input logic s);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_stat_o <= s;
      rx_dat_o <= d;
      rx_err_o <= err_i;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_stat_o <= 1'b0;
      rx_dat_o <= ~d;
      rx_err_o <= 1'b0;
   endtask
   // One message at a time; a reply starts five cycles after the last word.
   initial
   begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_stat_o = 1'b0;
      rx_dat_o = 16'h0000;
      rx_err_o = 1'b0;
      bc_r = 1'b0;
      me_r = 1'b0;
      rcvd = 0;
      forever
      begin
         take();
         cw = w;
         md = (cw[9:5] == 5'h00) || (cw[9:5] == 5'h1f);
         nrx = md ? int'(!cw[10] && cw[4]) : (cw[10] ? 0 : ((cw[4:0] == 5'h00) ? 32 : int'(cw[4:0])));
         ntx = md ? int'(cw[10] && cw[4]) : (!cw[10] ? 0 : ((cw[4:0] == 5'h00) ? 32 : int'(cw[4:0])));
         repeat (nrx)
         begin
            take();
            rcvd++;
         end
         live = !(bus_sel_i ? dead_b_i : dead_a_i);
         if (live && cw[15:11] == 5'h1f)
            bc_r = 1'b1;
         else if (live && cw[15:11] == MY_ADDR)
         begin
            if (!(md && cw[4:0] == 5'h02))
            begin
               bc_r = 1'b0;
               me_r = md && !LEGAL[cw[4:0]];
            end
            if (md && cw[4:0] == 5'h08)
            begin
               // Only the interface flags clear; the unit's own flags stand.
               bc_r = 1'b0;
               me_r = 1'b0;
            end
            repeat (4) @(posedge clk_i);
            send({flags_i[2], 1'b0, flags_i[1:0], bc_r, 5'h00, me_r, MY_ADDR}, 1'b1);
            for (int k = 0; k < ntx; k++)
               send(16'ha500 + 16'(k), 1'b0);
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/bmc_ctrl_tb.sv ***
// Self-checking bench for the bus controller against the terminal model.
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl_tb;
   localparam logic [4:0] MY = 5'h05;
   logic clk_i, rst_i, cmd_valid_i, cmd_tx_i, dat_valid_i, auto_en_i, sel_a_i, sel_b_i, lb_fail_i;
   logic [4:0] cmd_addr_i, cmd_sa_i, cmd_wc_i;
   logic [15:0] dat_i, rx_word_o, stat_o, tx_word_o, rx_dat_i, lastw;
   logic cmd_ready_o, cmd_refused_o, dat_ack_o, rx_word_valid_o, done_o, rt_fail_o, bus_b_o, bus_sel_o;
   logic tx_valid_o, tx_cmd_o, tx_ready_i, rx_valid_i, rx_stat_i, rx_err_i;
   logic [6:0] flt_o;
   logic [2:0] flags;
   logic dead_a, dead_b, err, refd, dn, rtf;
   int error_cnt = 0;
   int num_checks = 0;
   int nrx, nack;
   int nsync = 0;
   bmc_ctrl #(.SUBFRAME_CYCLES(2000)) bmc_ctrl_i (.*);
   bmc_rt_model #(.MY_ADDR(MY)) bmc_rt_model_i (.clk_i(clk_i), .tx_word_i(tx_word_o), .tx_valid_i(tx_valid_o),
      .tx_cmd_i(tx_cmd_o), .bus_sel_i(bus_sel_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
      .rx_stat_o(rx_stat_i), .rx_dat_o(rx_dat_i), .rx_err_o(rx_err_i), .dead_a_i(dead_a), .dead_b_i(dead_b),
      .err_i(err), .flags_i(flags));
   // Clock at 10 MHz.
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Counts frame syncs so that the expected subframe number is known.
   always @(posedge clk_i)
      if (tx_valid_o && tx_ready_i && tx_cmd_o && tx_word_o[15:11] == 5'h1f && tx_word_o[3:0] == 4'h1)
         nsync <= nsync + 1;
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Waits for the next word the encoder accepts.
   task automatic wacc();
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (!(tx_valid_o === 1'b1 && tx_ready_i === 1'b1) && n < 5000);
   endtask
   // Issues one command, holds it until taken, then follows it to refusal or completion.
   task automatic run(input logic [4:0] a, input logic t, input logic [4:0] sa, input logic [4:0] wc);
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 5000)
      begin
         @(posedge clk_i);
         n++;
      end
      cmd_valid_i <= 1'b1;
      cmd_addr_i <= a;
      cmd_tx_i <= t;
      cmd_sa_i <= sa;
      cmd_wc_i <= wc;
      do
         @(posedge clk_i);
      while (cmd_ready_o !== 1'b1);
      cmd_valid_i <= 1'b0;
      refd = 1'b0;
      dn = 1'b0;
      nrx = 0;
      nack = 0;
      for (n = 0; n < 3000 && !refd && !dn; n++)
      begin
         @(posedge clk_i);
         refd = cmd_refused_o === 1'b1;
         dn = done_o === 1'b1;
         rtf = rt_fail_o === 1'b1;
         if (rx_word_valid_o === 1'b1)
         begin
            nrx++;
            lastw = rx_word_o;
         end
         if (dat_ack_o === 1'b1)
         begin
            nack++;
            dat_i <= dat_i + 16'h0001;
         end
      end
      chk("message end", 16'(refd | dn), 16'h0001);
   endtask
   task automatic t_reset();
      chk("medium at reset", 16'(bus_b_o), 16'h0000);
      wacc();
      chk("first sync", tx_word_o, 16'hfc01);
      $display("test reset done");
   endtask
   // Every mode code, through both mode subaddresses in turn.
   task automatic t_modes();
      logic [31:0] acc;
      acc = 32'h000d_01fc;
      for (int c = 0; c < 32; c++)
      begin
         run(MY, c != 17, c[0] ? 5'h1f : 5'h00, 5'(c));
         chk("refused", 16'(refd), 16'(!acc[c]));
         if (acc[c])
            chk("status address", 16'(stat_o[4:0]), 16'(MY));
      end
      $display("test modes done");
   endtask
   task automatic t_sync();
      wacc();
      chk("sync word", tx_word_o, 16'hf811);
      lastw = {10'h000, nsync[5:0]};
      wacc();
      chk("sync data", tx_word_o, lastw);
      $display("test sync done");
   endtask
   // Runs straight after a sync, so no further sync falls inside it.
   task automatic t_bcast();
      run(5'h1f, 1'b0, 5'h03, 5'h02);
      chk("broadcast words", 16'(nack), 16'h0002);
      chk("broadcast no reply", 16'(flt_o[5]), 16'h0000);
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_STATUS);
      chk("broadcast bit", 16'(stat_o[11]), 16'h0001);
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_VECTOR);
      chk("broadcast bit clear", 16'(stat_o[11]), 16'h0000);
      $display("test broadcast done");
   endtask
   task automatic t_xfer();
      run(MY, 1'b1, 5'h03, 5'h00);
      chk("words in", 16'(nrx), 16'h0020);
      chk("last word in", lastw, 16'ha51f);
      run(MY, 1'b0, 5'h1e, 5'h03);
      chk("words out", 16'(nack), 16'h0003);
      $display("test transfer done");
   endtask
   task automatic t_flags();
      flags <= 3'b111;
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_VECTOR);
      chk("fault flags", 16'(flt_o[3:0]), 16'h000e);
      chk("status flags", stat_o & 16'hb800, 16'hb000);
      chk("status zeros", stat_o & 16'h4740, 16'h0000);
      flags <= 3'b000;
      $display("test flags done");
   endtask
   // Interface errors with reconfiguration off: recorded, no medium change.
   task automatic t_errs();
      auto_en_i <= 1'b0;
      err <= 1'b1;
      lb_fail_i <= 1'b1;
      @(posedge clk_i);
      lb_fail_i <= 1'b0;
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_STATUS);
      chk("tx and loop errors", 16'({flt_o[6], flt_o[4]}), 16'h0003);
      chk("medium kept", 16'(bus_b_o), 16'h0000);
      err <= 1'b0;
      auto_en_i <= 1'b1;
      $display("test errors done");
   endtask
   task automatic t_fdir();
      dead_a <= 1'b1;
      dead_b <= 1'b1;
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_VECTOR);
      chk("terminal failed", 16'({rtf, flt_o[5], bus_b_o}), 16'h0006);
      dead_b <= 1'b0;
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_VECTOR);
      @(posedge clk_i);
      chk("moved to b", 16'(bus_b_o), 16'h0001);
      dead_a <= 1'b0;
      dead_b <= 1'b1;
      run(MY, 1'b1, 5'h00, bmc_pkg::MC_TX_VECTOR);
      chk("stays on b", 16'({flt_o[5], bus_b_o}), 16'h0003);
      dead_b <= 1'b0;
      // Held long enough to outlast a frame sync, since selection waits for idle.
      sel_a_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      sel_a_i <= 1'b0;
      chk("manual back to a", 16'(bus_b_o), 16'h0000);
      sel_b_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      sel_b_i <= 1'b0;
      chk("manual to b", 16'(bus_b_o), 16'h0001);
      $display("test medium done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence; every input starts at a defined value.
   initial
   begin
      rst_i = 1'b1;
      {cmd_valid_i, cmd_tx_i, sel_a_i, sel_b_i, lb_fail_i, dead_a, dead_b, err} = 8'h00;
      {cmd_addr_i, cmd_sa_i, cmd_wc_i} = 15'h0000;
      dat_valid_i = 1'b1;
      auto_en_i = 1'b1;
      dat_i = 16'h1230;
      flags = 3'b000;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_modes();
      t_sync();
      t_bcast();
      t_xfer();
      t_flags();
      t_errs();
      t_fdir();
      give_verdict();
   end
   // Cuts a hang short; the tests need well under a third of this span.
   initial
   begin
      repeat (30000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire
